// [ovr_pkg.sv]
// Overview of operation
// - dual mode rising edge, single both edges
// - negative input higher gives negative code
// - codes span -2048 to +2047 signed
// - compare upper 8 bits of magnitude
// - 11-bit magnitude, most negative saturates
// - same thresholds for both channels
// - flag set when magnitude meets threshold
// - index zero channel a, index one channel b
// - pulse length 8 to 1024 cycles
// - complex: I gets upper, Q lower
// - real: even gets upper, odd lower
// - window 2^(n+1) real, 2^n complex
// - embedded bit high on any hit
// - calibration foreground halts, background samples
package ovr_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int SAMPLE_W = 12;
	localparam int MAG_W = 11;
	localparam int THR_W = 8;
	localparam int SEL_W = 3;
	localparam int DEC_W = 16;
	localparam int CNT_W = 11;
	localparam int WIN_W = 9;
	localparam int MODE_W = 5;
	localparam int CAL_W = 8;

	// ----------------------------------------
	// codes and counts
	// ----------------------------------------
	localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 12'h800;
	localparam logic [SAMPLE_W-1:0] SAMPLE_ONE = 12'h001;
	localparam logic [MAG_W-1:0] MAG_MAX = 11'h7ff;
	localparam int CMP_LSB = 3;
	localparam logic [CNT_W-1:0] BASE_PULSE = 11'h008;
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
	localparam logic [WIN_W-1:0] BASE_WIN = 9'h001;
	localparam logic [MODE_W-1:0] MODE_REAL = 5'h09;
	localparam logic [MODE_W-1:0] MODE_CPLX_LO = 5'h0a;
	localparam logic [MODE_W-1:0] MODE_CPLX_HI = 5'h10;
	localparam logic [MODE_W-1:0] MODE_CPLX_SKIP = 5'h0c;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [THR_W-1:0] UPPER_THR_RST = 8'he4;
	localparam logic [THR_W-1:0] LOWER_THR_RST = 8'h40;
	localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

	// ----------------------------------------
	// calibration timing
	// ----------------------------------------
	localparam int CAL_TIME_NS = 6400;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CAL_CYCLES_INT = CAL_TIME_NS / CLK_PERIOD_NS;
	localparam logic [CAL_W-1:0] CAL_CYCLES = CAL_W'(CAL_CYCLES_INT);
	localparam logic [CAL_W-1:0] CAL_ONE = 8'h01;

	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'b00,
		CAL_FG = 2'b01,
		CAL_BG = 2'b10
	} cal_state_t;
endpackage : ovr_pkg

// [ovr_chan_if.sv]
`timescale 1ns/1ps
// one channel's sample stream and its threshold hits
interface ovr_chan_if;
	logic valid;
	logic [ovr_pkg::SAMPLE_W-1:0] sample;
	logic hit_upper;
	logic hit_lower;
	modport cmp (input valid, input sample, output hit_upper, output hit_lower);
	modport core (output valid, output sample, input hit_upper, input hit_lower);
endinterface : ovr_chan_if

// [ovr_compare.sv]
`timescale 1ns/1ps
module ovr_compare
(
	input wire logic clk_i, // sampling clock
	input wire logic rst_i, // sync reset, high
	input wire logic [ovr_pkg::THR_W-1:0] upper_thr_i, // upper threshold
	input wire logic [ovr_pkg::THR_W-1:0] lower_thr_i, // lower threshold
	ovr_chan_if.cmp chan // sample in, hits out
);
	logic [ovr_pkg::SAMPLE_W-1:0] neg;
	logic [ovr_pkg::MAG_W-1:0] mag;
	logic [ovr_pkg::THR_W-1:0] top;
	logic hit_upper_reg;
	logic hit_lower_reg;

	// ----------------------------------------
	// magnitude
	// ----------------------------------------
	// negation alone would wrap the most negative code to itself
	always_comb
	begin
		neg = ovr_pkg::SAMPLE_W'(~chan.sample + ovr_pkg::SAMPLE_ONE);
		if (!chan.sample[ovr_pkg::SAMPLE_W-1])
			mag = chan.sample[ovr_pkg::MAG_W-1:0];
		else if (chan.sample == ovr_pkg::SAMPLE_MIN)
			mag = ovr_pkg::MAG_MAX;
		else
			mag = neg[ovr_pkg::MAG_W-1:0];
		top = mag[ovr_pkg::MAG_W-1:ovr_pkg::CMP_LSB];
	end

	// ----------------------------------------
	// threshold compare
	// ----------------------------------------
	// registered so the hit path has a single cycle of latency
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hit_upper_reg <= 1'b0;
			hit_lower_reg <= 1'b0;
		end
		else
		begin
			hit_upper_reg <= chan.valid && (top >= upper_thr_i);
			hit_lower_reg <= chan.valid && (top >= lower_thr_i);
		end
	end

	assign chan.hit_upper = hit_upper_reg;
	assign chan.hit_lower = hit_lower_reg;

	AST_CMP_SATURATE: assert property (@(posedge clk_i) disable iff (rst_i)
		chan.valid && chan.sample == ovr_pkg::SAMPLE_MIN |=> chan.hit_upper && chan.hit_lower)
		else $error("most negative code did not hit both thresholds");
	AST_CMP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		chan.valid && chan.sample == '0 && upper_thr_i != '0 |=> !chan.hit_upper)
		else $error("zero sample hit a nonzero threshold");
	AST_CMP_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
		!chan.valid |=> !chan.hit_upper && !chan.hit_lower)
		else $error("hit without a valid sample");
endmodule : ovr_compare

// [ovr_stretch.sv]
`timescale 1ns/1ps
module ovr_stretch
(
	input wire logic clk_i, // sampling clock
	input wire logic rst_i, // sync reset, high
	input wire logic hit_i, // threshold hit this cycle
	input wire logic [ovr_pkg::SEL_W-1:0] sel_i, // pulse length select
	output logic flag_o // stretched status pin
);
	logic [ovr_pkg::CNT_W-1:0] cnt_reg;
	logic [ovr_pkg::CNT_W-1:0] len;
	logic flag_reg;

	// 8 << sel gives 8 .. 1024 cycles
	assign len = ovr_pkg::BASE_PULSE << sel_i;

	// ----------------------------------------
	// pulse counter
	// ----------------------------------------
	// every hit reloads, so the pin drops a full length after the last one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_reg <= '0;
		else if (hit_i)
			cnt_reg <= len;
		else if (cnt_reg != '0)
			cnt_reg <= ovr_pkg::CNT_W'(cnt_reg - ovr_pkg::CNT_ONE);
	end

	// flag comes from a flop so the pin is glitch free
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_reg <= 1'b0;
		else
			flag_reg <= hit_i || (cnt_reg > ovr_pkg::CNT_ONE);
	end

	assign flag_o = flag_reg;

	sequence hit_then_quiet;
		hit_i && sel_i == '0 ##1 (!hit_i && sel_i == '0) [*8];
	endsequence

	AST_PULSE_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
		hit_i |=> flag_o [*8])
		else $error("status pulse shorter than minimum");
	AST_PULSE_END: assert property (@(posedge clk_i) disable iff (rst_i)
		hit_then_quiet |=> !flag_o)
		else $error("status pulse longer than selected length");
endmodule : ovr_stretch

// [ovr_detector.sv]
`timescale 1ns/1ps
module ovr_detector
(
	input wire logic clk_i, // sampling clock
	input wire logic rst_i, // sync reset, high
	input wire logic single_channel_i, // 1: one input, both edges
	input wire logic [11:0] chan_a_sample_i, // rising edge sample
	input wire logic [11:0] chan_b_sample_i, // b or falling edge sample
	input wire logic cfg_write_i, // load configuration
	input wire logic [7:0] upper_threshold_i, // upper threshold value
	input wire logic [7:0] lower_threshold_i, // lower threshold value
	input wire logic [2:0] pulse_length_select_i, // pulse length code
	input wire logic [4:0] link_mode_select_i, // output mode code
	input wire logic dec_valid_i, // decimated sample strobe
	input wire logic dec_is_q_i, // complex: sample is Q
	input wire logic [15:0] dec_a_sample_i, // decimated a sample
	input wire logic [15:0] dec_b_sample_i, // decimated b sample
	input wire logic cal_start_i, // start calibration pulse
	input wire logic cal_background_i, // 1: background calibration
	output logic [11:0] chan_a_data_o, // channel a code
	output logic [11:0] chan_b_data_o, // channel b code
	output logic data_valid_o, // codes valid
	output logic chan_a_upper_flag_o, // a upper status pin
	output logic chan_a_lower_flag_o, // a lower status pin
	output logic chan_b_upper_flag_o, // b upper status pin
	output logic chan_b_lower_flag_o, // b lower status pin
	output logic dec_valid_o, // decimated output strobe
	output logic [15:0] dec_a_sample_o, // a with embedded status
	output logic [15:0] dec_b_sample_o, // b with embedded status
	output logic cal_busy_o // calibration running
);
	localparam int CalN = ovr_pkg::CAL_CYCLES_INT;

	logic [ovr_pkg::THR_W-1:0] upper_thr_reg;
	logic [ovr_pkg::THR_W-1:0] lower_thr_reg;
	logic [ovr_pkg::SEL_W-1:0] sel_reg;
	ovr_pkg::cal_state_t cal_state_reg;
	logic [ovr_pkg::CAL_W-1:0] cal_cnt_reg;
	logic sampling_en;
	logic mode_real;
	logic mode_cplx;
	logic emb_on;
	logic [ovr_pkg::WIN_W-1:0] win_len;
	logic parity_reg;
	logic use_lower;
	logic [ovr_pkg::SAMPLE_W-1:0] smp [2];
	logic [ovr_pkg::DEC_W-1:0] dec_in [2];
	logic [ovr_pkg::DEC_W-1:0] dec_out [2];
	logic [ovr_pkg::SAMPLE_W-1:0] data_out [2];
	logic flag_up [2];
	logic flag_lo [2];
	logic emb_up [2];
	logic emb_lo [2];

	// ----------------------------------------
	// configuration storage
	// ----------------------------------------
	// held here so a change lands on both channels in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			upper_thr_reg <= ovr_pkg::UPPER_THR_RST;
			lower_thr_reg <= ovr_pkg::LOWER_THR_RST;
			sel_reg <= ovr_pkg::SEL_RST;
		end
		else if (cfg_write_i)
		begin
			upper_thr_reg <= upper_threshold_i;
			lower_thr_reg <= lower_threshold_i;
			sel_reg <= pulse_length_select_i;
		end
	end

	// ----------------------------------------
	// calibration control
	// ----------------------------------------
	// a start while busy is ignored; the running pass finishes first
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cal_state_reg <= ovr_pkg::CAL_IDLE;
			cal_cnt_reg <= '0;
		end
		else
		begin
			case (cal_state_reg)
				ovr_pkg::CAL_IDLE:
				begin
					if (cal_start_i)
					begin
						cal_state_reg <= cal_background_i ? ovr_pkg::CAL_BG : ovr_pkg::CAL_FG;
						cal_cnt_reg <= ovr_pkg::CAL_CYCLES;
					end
				end
				ovr_pkg::CAL_FG, ovr_pkg::CAL_BG:
				begin
					if (cal_cnt_reg == ovr_pkg::CAL_ONE)
						cal_state_reg <= ovr_pkg::CAL_IDLE;
					cal_cnt_reg <= ovr_pkg::CAL_W'(cal_cnt_reg - ovr_pkg::CAL_ONE);
				end
				default:
				begin
					cal_state_reg <= ovr_pkg::CAL_IDLE;
					cal_cnt_reg <= '0;
				end
			endcase
		end
	end

	// foreground pass takes the converter offline
	assign sampling_en = (cal_state_reg != ovr_pkg::CAL_FG);
	assign cal_busy_o = (cal_state_reg != ovr_pkg::CAL_IDLE);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// embedding only exists in the dual-channel decimating modes
	assign mode_real = (link_mode_select_i == ovr_pkg::MODE_REAL);
	assign mode_cplx = (link_mode_select_i >= ovr_pkg::MODE_CPLX_LO)
		&& (link_mode_select_i <= ovr_pkg::MODE_CPLX_HI)
		&& (link_mode_select_i != ovr_pkg::MODE_CPLX_SKIP);
	assign emb_on = !single_channel_i && (mode_real || mode_cplx);
	// real mode window is twice the complex one for the same code
	assign win_len = mode_real ? ((ovr_pkg::BASE_WIN << sel_reg) << 1)
		: (ovr_pkg::BASE_WIN << sel_reg);

	// even / odd tracking of real decimated samples
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !mode_real)
			parity_reg <= 1'b0;
		else if (dec_valid_i)
			parity_reg <= !parity_reg;
	end

	assign use_lower = mode_real ? parity_reg : dec_is_q_i;

	// lane b carries the falling edge sample in single-channel mode
	assign smp[0] = chan_a_sample_i;
	assign smp[1] = chan_b_sample_i;
	assign dec_in[0] = dec_a_sample_i;
	assign dec_in[1] = dec_b_sample_i;

	// ----------------------------------------
	// per-channel datapath
	// ----------------------------------------
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		ovr_chan_if chif ();
		logic [ovr_pkg::WIN_W-1:0] win_cnt_reg;
		logic acc_up_reg;
		logic acc_lo_reg;
		logic emb_up_reg;
		logic emb_lo_reg;
		logic [ovr_pkg::SAMPLE_W-1:0] data_reg;
		logic [ovr_pkg::DEC_W-1:0] dec_reg;

		assign chif.valid = sampling_en;
		assign chif.sample = smp[ch];

		// one threshold pair shared by both channels
		ovr_compare u_cmp
		(
			.clk_i(clk_i),
			.rst_i(rst_i),
			.upper_thr_i(upper_thr_reg),
			.lower_thr_i(lower_thr_reg),
			.chan(chif.cmp)
		);

		ovr_stretch u_str_up
		(
			.clk_i(clk_i),
			.rst_i(rst_i),
			.hit_i(chif.hit_upper),
			.sel_i(sel_reg),
			.flag_o(flag_up[ch])
		);

		ovr_stretch u_str_lo
		(
			.clk_i(clk_i),
			.rst_i(rst_i),
			.hit_i(chif.hit_lower),
			.sel_i(sel_reg),
			.flag_o(flag_lo[ch])
		);

		// sample codes pass through unchanged as signed values
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				data_reg <= '0;
			else if (sampling_en)
				data_reg <= smp[ch];
		end

		// window counter, restarted by wrap or by embedding turning off, not by a length change
		always_ff @(posedge clk_i)
		begin
			if (rst_i || !emb_on)
				win_cnt_reg <= '0;
			else if (sampling_en)
			begin
				if (win_cnt_reg >= ovr_pkg::WIN_W'(win_len - ovr_pkg::BASE_WIN))
					win_cnt_reg <= '0;
				else
					win_cnt_reg <= ovr_pkg::WIN_W'(win_cnt_reg + ovr_pkg::BASE_WIN);
			end
		end

		// a hit in the closing cycle still counts toward that window
		always_ff @(posedge clk_i)
		begin
			if (rst_i || !emb_on)
			begin
				acc_up_reg <= 1'b0;
				acc_lo_reg <= 1'b0;
				emb_up_reg <= 1'b0;
				emb_lo_reg <= 1'b0;
			end
			else if (sampling_en
				&& win_cnt_reg >= ovr_pkg::WIN_W'(win_len - ovr_pkg::BASE_WIN))
			begin
				emb_up_reg <= acc_up_reg || chif.hit_upper;
				emb_lo_reg <= acc_lo_reg || chif.hit_lower;
				acc_up_reg <= 1'b0;
				acc_lo_reg <= 1'b0;
			end
			else
			begin
				acc_up_reg <= acc_up_reg || chif.hit_upper;
				acc_lo_reg <= acc_lo_reg || chif.hit_lower;
			end
		end

		// lsb replaced only while embedding is on
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				dec_reg <= '0;
			else if (dec_valid_i)
			begin
				if (emb_on)
					dec_reg <= {dec_in[ch][ovr_pkg::DEC_W-1:1],
						use_lower ? emb_lo_reg : emb_up_reg};
				else
					dec_reg <= dec_in[ch];
			end
		end

		assign emb_up[ch] = emb_up_reg;
		assign emb_lo[ch] = emb_lo_reg;
		assign data_out[ch] = data_reg;
		assign dec_out[ch] = dec_reg;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_valid_o <= 1'b0;
			dec_valid_o <= 1'b0;
		end
		else
		begin
			data_valid_o <= sampling_en;
			dec_valid_o <= dec_valid_i;
		end
	end

	// index zero is channel a, index one channel b
	assign chan_a_upper_flag_o = flag_up[0];
	assign chan_a_lower_flag_o = flag_lo[0];
	assign chan_b_upper_flag_o = flag_up[1];
	assign chan_b_lower_flag_o = flag_lo[1];
	assign chan_a_data_o = data_out[0];
	assign chan_b_data_o = data_out[1];
	assign dec_a_sample_o = dec_out[0];
	assign dec_b_sample_o = dec_out[1];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence cal_fg_begin;
		cal_state_reg == ovr_pkg::CAL_IDLE && cal_start_i && !cal_background_i;
	endsequence

	sequence cal_bg_begin;
		cal_state_reg == ovr_pkg::CAL_IDLE && cal_start_i && cal_background_i;
	endsequence

	AST_CAL_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
		cal_fg_begin |=> cal_busy_o ##CalN !cal_busy_o)
		else $error("calibration pass length wrong");
	AST_CAL_FG_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
		cal_fg_begin ##1 cal_busy_o |=> !data_valid_o)
		else $error("sampling continued during foreground calibration");
	AST_CAL_BG_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
		cal_bg_begin |=> ##1 data_valid_o [*8])
		else $error("sampling stopped during background calibration");
	AST_CFG_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_write_i ##1 !cfg_write_i [*2] |-> upper_thr_reg == $past(upper_threshold_i, 2))
		else $error("threshold not held after write");
	AST_EMB_EVEN: assert property (@(posedge clk_i) disable iff (rst_i)
		dec_valid_i && emb_on && mode_real && !parity_reg
		|=> dec_a_sample_o[0] == $past(emb_up[0]))
		else $error("even real sample lsb not upper status");
	AST_EMB_Q: assert property (@(posedge clk_i) disable iff (rst_i)
		dec_valid_i && emb_on && mode_cplx && dec_is_q_i
		|=> dec_b_sample_o[0] == $past(emb_lo[1])
		&& dec_b_sample_o[15:1] == $past(dec_b_sample_i[15:1]))
		else $error("Q sample lsb not lower status");
	AST_EMB_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
		emb_on && sampling_en && sel_reg == '0 && mode_cplx
		&& g_chan[0].chif.hit_upper |=> emb_up[0])
		else $error("single-sample window missed a hit");
endmodule : ovr_detector

// [ovr_downstream.sv]
`timescale 1ns/1ps
// downstream logic watching the channel a status pins, and the b pins in single mode
module ovr_downstream
#(
	parameter int QUIET_CYCLES = 256 // plain default
)
(
	input wire logic clk_i, // sampling clock
	input wire logic rst_i, // sync reset, high
	input wire logic single_channel_i, // 1: one input, both edges
	input wire logic [3:0] flags_i, // a upper, a lower, b upper, b lower
	output logic upper_any_o, // upper threshold tripped
	output logic lower_any_o, // lower threshold tripped
	output logic raise_gain_o // lower flag quiet long enough
);
	int quiet_cnt;

	// in single mode the two lanes carry alternate edges of one input
	assign upper_any_o = flags_i[0] | (single_channel_i & flags_i[2]);
	assign lower_any_o = flags_i[1] | (single_channel_i & flags_i[3]);

	// gain may rise only after the lower flag stayed low a long time
	always @(posedge clk_i)
	begin
		if (rst_i || lower_any_o)
			quiet_cnt <= 0;
		else if (quiet_cnt < QUIET_CYCLES)
			quiet_cnt <= quiet_cnt + 1;
	end
	assign raise_gain_o = (quiet_cnt == QUIET_CYCLES);
endmodule : ovr_downstream

// [tb_adc_overrange_detector.sv]
`timescale 1ns/1ps
module tb_adc_overrange_detector;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic single_channel_i = 1'b0;
	logic [11:0] sa = 12'h000, sb = 12'h000;
	logic cfg_write_i = 1'b0;
	logic [7:0] ut = 8'he4, lt = 8'h40;
	logic [2:0] ps = 3'h0;
	logic [4:0] mode = 5'h00;
	logic dvi = 1'b0, isq = 1'b0;
	logic [15:0] dai = 16'h0000, dbi = 16'h0000;
	logic cal_start_i = 1'b0, cal_background_i = 1'b0;
	logic [11:0] da_o, db_o;
	logic dv_o, dvo_o, busy_o, up_any, lo_any, rg;
	wire [3:0] fl_o;
	logic [15:0] dao_o, dbo_o;
	int num_errors = 0;
	int samples_checked = 0;
	logic [15:0] rnd = 16'h3527; // seed 13607
	logic [11:0] corner [8] = '{12'h800, 12'h810, 12'h7ff, 12'h7f0, 12'h720, 12'h71f,
		12'h200, 12'h1ff};
	logic [4:0] modes [10] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
		5'h00, 5'h09};

	ovr_detector i_dut
	(
		.clk_i(clk_i), .rst_i(rst_i), .single_channel_i(single_channel_i),
		.chan_a_sample_i(sa), .chan_b_sample_i(sb), .cfg_write_i(cfg_write_i),
		.upper_threshold_i(ut), .lower_threshold_i(lt), .pulse_length_select_i(ps),
		.link_mode_select_i(mode), .dec_valid_i(dvi), .dec_is_q_i(isq),
		.dec_a_sample_i(dai), .dec_b_sample_i(dbi), .cal_start_i(cal_start_i),
		.cal_background_i(cal_background_i), .chan_a_data_o(da_o), .chan_b_data_o(db_o),
		.data_valid_o(dv_o), .chan_a_upper_flag_o(fl_o[0]), .chan_a_lower_flag_o(fl_o[1]),
		.chan_b_upper_flag_o(fl_o[2]), .chan_b_lower_flag_o(fl_o[3]),
		.dec_valid_o(dvo_o), .dec_a_sample_o(dao_o), .dec_b_sample_o(dbo_o),
		.cal_busy_o(busy_o)
	);

	ovr_downstream i_ds
	(
		.clk_i(clk_i), .rst_i(rst_i), .single_channel_i(single_channel_i),
		.flags_i(fl_o), .upper_any_o(up_any), .lower_any_o(lo_any), .raise_gain_o(rg)
	);

	// 100 ns period
	always #50 clk_i = ~clk_i;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	// most negative code has no positive twin, so it saturates
	function automatic logic [7:0] mag8(input logic [11:0] s);
		logic [11:0] m;
		m = s[11] ? -s : s;
		return (s == 12'h800) ? 8'hff : m[10:3];
	endfunction : mag8

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic drive(input logic [11:0] a, input logic [11:0] b, input int n);
		sa <= a;
		sb <= b;
		repeat (n) @(posedge clk_i);
	endtask : drive

	task automatic cfg(input logic [7:0] u, input logic [7:0] l, input logic [2:0] s);
		ut <= u;
		lt <= l;
		ps <= s;
		cfg_write_i <= 1'b1;
		@(posedge clk_i);
		cfg_write_i <= 1'b0;
	endtask : cfg

	task automatic cal(input logic bg);
		cal_background_i <= bg;
		cal_start_i <= 1'b1;
		@(posedge clk_i);
		cal_start_i <= 1'b0;
	endtask : cal

	task automatic dec(input int n);
		repeat (n)
		begin
			rnd = lfsr(rnd);
			dvi <= 1'b1;
			isq <= rnd[0];
			dai <= rnd;
			dbi <= {rnd[7:0], rnd[15:8]};
			@(posedge clk_i);
		end
		dvi <= 1'b0;
	endtask : dec

	// ----------------------------------------
	// reference model, one step per edge
	// ----------------------------------------
	logic [7:0] mu, ml;
	logic [2:0] msel;
	logic [3:0] hq, fl;
	logic [10:0] cnt [4];
	logic [6:0] cal_cnt;
	logic fg, en, dv, dvo, par, slot, emb, lsb_cmp;
	logic emb_ok = 1'b0, emb_u = 1'b0, emb_l = 1'b0;
	int quiet = 0;
	logic [11:0] da, db;
	logic [15:0] dao, dbo;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mu = 8'he4;
			ml = 8'h40;
			msel = 3'h0;
			hq = 4'h0;
			fl = 4'h0;
			foreach (cnt[i]) cnt[i] = 11'h000;
			cal_cnt = 7'h00;
			fg = 1'b0;
			dv = 1'b0;
			da = 12'h000;
			db = 12'h000;
			dvo = 1'b0;
			dao = 16'h0000;
			dbo = 16'h0000;
			par = 1'b0;
			lsb_cmp = 1'b1;
			quiet = 0;
		end
		else
		begin
			// downstream sees the pins as they stood before this edge
			if (fl[1] | (single_channel_i & fl[3]))
				quiet = 0;
			else if (quiet < 256)
				quiet++;
			en = !(cal_cnt != 7'h00 && fg);
			for (int i = 0; i < 4; i++)
			begin
				if (hq[i])
				begin
					fl[i] = 1'b1;
					cnt[i] = (11'h008 << msel) - 11'h001;
				end
				else if (cnt[i] != 11'h000)
					cnt[i] = cnt[i] - 11'h001;
				else
					fl[i] = 1'b0;
			end
			hq = {mag8(sb) >= ml, mag8(sb) >= mu, mag8(sa) >= ml, mag8(sa) >= mu} & {4{en}};
			if (cal_cnt != 7'h00)
				cal_cnt = cal_cnt - 7'h01;
			else if (cal_start_i)
			begin
				cal_cnt = 7'h40;
				fg = !cal_background_i;
			end
			dv = en;
			if (en)
			begin
				da = sa;
				db = sb;
			end
			emb = !single_channel_i && (mode == 5'h09 || (mode >= 5'h0a && mode <= 5'h10
				&& mode != 5'h0c));
			if (mode != 5'h09)
				par = 1'b0;
			dvo = dvi;
			if (dvi)
			begin
				slot = (mode == 5'h09) ? par : isq;
				dao = {dai[15:1], emb ? (slot ? emb_l : emb_u) : dai[0]};
				dbo = {dbi[15:1], emb ? (slot ? emb_l : emb_u) : dbi[0]};
				lsb_cmp = !emb || emb_ok;
				// parity only runs in real mode; it starts even on entry
				par = (mode == 5'h09) && !par;
			end
			if (cfg_write_i)
			begin
				mu = ut;
				ml = lt;
				msel = ps;
			end
		end
	end

	// compare at the falling edge, when outputs have settled
	always @(negedge clk_i)
	begin
		check(16'(fl_o), 16'(fl));
		check({da_o, 4'h0}, {da, 4'h0});
		check({db_o, 4'h0}, {db, 4'h0});
		check({dv_o, busy_o, 14'h0000}, {dv, cal_cnt != 7'h00, 14'h0000});
		check({up_any, lo_any, rg, 13'h0000}, {fl[0] | (single_channel_i & fl[2]),
			fl[1] | (single_channel_i & fl[3]), quiet == 256, 13'h0000});
		check(16'(dvo_o), 16'(dvo));
		check(dao_o & {15'h7fff, lsb_cmp}, dao & {15'h7fff, lsb_cmp});
		check(dbo_o & {15'h7fff, lsb_cmp}, dbo & {15'h7fff, lsb_cmp});
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// threshold boundaries, positive and negated codes
		foreach (corner[k]) drive(corner[k], -corner[k], 3);
		drive(12'h000, 12'h000, 12);
		// every pulse length, with a restart halfway through
		for (int s = 0; s < 8; s++)
		begin
			rnd = lfsr(rnd);
			cfg(rnd[7:0] | 8'h01, rnd[15:8] | 8'h01, s[2:0]);
			drive(12'h800, 12'h7ff, 1);
			drive(12'h000, 12'h000, 4 << s);
			drive(12'h800, 12'h800, 1);
			drive(12'h000, 12'h000, (8 << s) + 4);
		end
		// random codes and thresholds, mode toggling; length held fixed
		for (int h = 0; h < 2; h++)
		begin
			rnd = lfsr(rnd);
			cfg(rnd[7:0] | 8'h01, rnd[15:8] | 8'h01, 3'h1);
			repeat (150)
			begin
				rnd = lfsr(rnd);
				single_channel_i <= rnd[1];
				drive(rnd[11:0], {rnd[3:0], rnd[15:8]}, 1);
			end
		end
		single_channel_i <= 1'b0;
		drive(12'h000, 12'h000, 24);
		// foreground halts sampling, a second start while busy is ignored
		cal(1'b0);
		drive(12'h800, 12'h800, 30);
		cal(1'b1);
		drive(12'h800, 12'h800, 40);
		drive(12'h000, 12'h000, 24);
		cal(1'b1);
		drive(12'h800, 12'h000, 70);
		drive(12'h000, 12'h000, 24);
		// embedded status in each link mode, two signal levels
		for (int lvl = 0; lvl < 2; lvl++)
		begin
			// full-scale pass uses the shortest window, one sample complex and two real, so a hit lands at once
			cfg(8'he4, 8'h40, lvl[0] ? 3'h0 : 3'h2);
			foreach (modes[m])
			begin
				single_channel_i <= (m == 9);
				mode <= modes[m];
				emb_u <= lvl[0];
				emb_l <= 1'b1;
				drive(lvl[0] ? 12'h800 : 12'h320, lvl[0] ? 12'h800 : 12'h320, 40);
				emb_ok <= 1'b1;
				dec(6);
				emb_ok <= 1'b0;
			end
		end
		// long quiet tail lets downstream decide to raise gain
		drive(12'h000, 12'h000, 300);
		stop_test();
	end

	// watchdog, about four times the expected run
	initial
	begin
		#2000000;
		num_errors++;
		stop_test();
	end
endmodule : tb_adc_overrange_detector
